// [link_master_model.sv]
// model of the master controller frame results on the serial link
`timescale 1ns/10ps
module link_master_model (
    input  wire       mclk,
    input  wire       send,
    input  wire [1:0] dev_parity,
    input  wire       dev_two_stop,
    input  wire [1:0] mst_parity,
    input  wire       mst_two_stop,
    output reg        link_frame_ok,
    output reg        link_frame_err
);
    // ****************
    // a frame survives only when both ends agree on framing
    // ****************
    wire match = (dev_parity == mst_parity)
               && (dev_two_stop == mst_two_stop);
    initial begin
        link_frame_ok  = 1'b0;
        link_frame_err = 1'b0;
    end
    always @(posedge mclk) begin
        link_frame_ok  <= send && match;
        link_frame_err <= send && !match;
    end
endmodule

// [pulse_timer.v]
// limit-tick up-counter, TICK_CYC cycles per tick, used for link supervision
`timescale 1ns/10ps
module pulse_timer #(
    parameter TICK_CYC = 20000,
    parameter W        = 14
) (
    input  wire         mclk,
    input  wire         reset,
    input  wire         clk_en,
    input  wire         restart,
    input  wire [W-1:0] limit,
    output reg          expired_ff
);
    reg [31:0]  tick_ff;
    reg [W-1:0] cnt_ff;
    always @(posedge mclk) begin
        if (reset) begin
            tick_ff    <= 32'h0;
            cnt_ff     <= {W{1'b0}};
            expired_ff <= 1'b0;
        end else if (clk_en) begin
            expired_ff <= 1'b0;
            if (restart || limit == {W{1'b0}}) begin
                tick_ff <= 32'h0;
                cnt_ff  <= {W{1'b0}};
            end else if (tick_ff == TICK_CYC - 1) begin
                tick_ff <= 32'h0;
                if (cnt_ff == limit - 1'b1) begin
                    cnt_ff     <= {W{1'b0}};
                    expired_ff <= 1'b1;
                end else begin
                    cnt_ff <= cnt_ff + 1'b1;
                end
            end else begin
                tick_ff <= tick_ff + 32'h1;
            end
        end
    end
endmodule

// [stepper_cfg_defines.vh]
// constants for the stepper drive configuration and control block
`ifndef STEPPER_CFG_DEFINES_VH
`define STEPPER_CFG_DEFINES_VH
// register offsets (word index on the plain port)
`define REG_CTRL        4'h0
`define REG_POS_LIMIT   4'h1
`define REG_NEG_LIMIT   4'h2
`define REG_COMM        4'h3
`define REG_RX_PERIOD   4'h4
`define REG_TIMEOUT     4'h5
`define REG_GEAR_A      4'h6
`define REG_GEAR_B      4'h7
`define REG_POS_CMD     4'h8
`define REG_POS_ACT     4'h9
`define REG_STATUS      4'ha
`define REG_IRQ_STAT    4'hb
`define REG_IRQ_MASK    4'hc
`define REG_MOTION      4'hd
// control register fields
`define CTRL_SW_OT      0
`define CTRL_DIR        1
`define CTRL_STEPOUT_EN 2
`define CTRL_HIRES      3
`define CTRL_STOP_NC    4
`define CTRL_TO_DECEL   5
`define CTRL_ANGLE_LSB  8
`define CTRL_SO_LSB     12
`define CTRL_RESET      32'h0000_0033
// comm register fields
`define COMM_PROTO      0
`define COMM_PAR_LSB    1
`define COMM_STOP2      3
`define COMM_ERRLIM_LSB 4
`define COMM_RESET      32'h0000_0032
// limits and defaults
`define POS_LIMIT_RESET 24'h7f_ffff
`define NEG_LIMIT_RESET 24'h80_0000
`define GEAR_RESET      18'h001f4
`define RXP_MAX         10'h3e7
`define TO_MAX          14'h2710
// interrupt bits
`define IRQ_SW_OT       0
`define IRQ_TIMEOUT     1
`define IRQ_STEPOUT     2
`define IRQ_COMM_ERR    3
`define IRQ_RXP         4
// timing
`define READY_TIME_MS   1500
`define CLK_HZ          20000000
`define CYC_PER_MS      (`CLK_HZ / 1000)
`define CYC_PER_10MS    (`CLK_HZ / 100)
`endif

// [stepper_drive_config_control.v]
// configuration, supervision and run gating of the stepper drive
// ****************
// Overview of operation
// R1: signed 24-bit travel limits, defaults most negative and most positive
// R2: software overtravel enabled stops motion and blocks that direction
// R3: link timeout stops motor; 0 immediate, 1 decelerating, default decel
// R4: legacy receive period 0 disables, else 0.01 to 9.99 s, default 0
// R5: receive period supervision only active under the legacy protocol
// R6: stepout reaction 0 none, 1 warning, 2 alarm; default none
// R7: gear A and B feed only misstep check, encoder count untouched
// R8: 4-bit angle code selects division 1 to 250, default code 0
// R9: high-resolution motors use 0.36 degree base step angle
// R10: protocol code 0 Modbus RTU, 1 legacy protocol, default Modbus
// R11: parity 0 none, 1 even, 2 odd, default even; master matches
// R12: stop bits code 0 one, code 1 two, default one; both ends match
// R13: Modbus timeout 0 unmonitored, else 1 to 10000 ms, default 0
// R14: parity, stop bits and timeout apply only under Modbus RTU
// R15: consecutive link errors raise alarm at limit 1 to 10, default 3
// R16: ready asserts after power-up with stop inactive, then start allowed
// R17: run requests accepted only after ready asserts
// R18: with stepout detection on, ready comes within 1.5 s
// R19: stop contact sense 0 normally open, 1 normally closed, default 1
// ****************
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/10ps
`include "stepper_cfg_defines.vh"
module stepper_drive_config_control #(
    parameter READY_CYC = `READY_TIME_MS * `CYC_PER_MS
) (
    input  wire        mclk,
    input  wire        reset,
    input  wire        clk_en,
    input  wire [3:0]  addr,
    input  wire [31:0] wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [31:0] rdata_ff,
    input  wire        stop_pin,
    input  wire        start_pin,
    input  wire        forward_run_request,
    input  wire        reverse_run_request,
    input  wire        link_frame_ok,
    input  wire        link_frame_err,
    input  wire        stepout_det,
    output reg         ready_ff,
    output reg         move_start_ff,
    output reg         run_fwd_ff,
    output reg         run_rev_ff,
    output reg         halt_ff,
    output reg         halt_decel_ff,
    output reg         warning_ff,
    output reg         alarm_ff,
    output reg         irq_ff
);
    // ****************
    // helpers
    // ****************
    function [15:0] div_x10;
        input [3:0] code;
        begin
            case (code)
                4'h0: div_x10 = 16'd10;
                4'h1: div_x10 = 16'd20;
                4'h2: div_x10 = 16'd25;
                4'h3: div_x10 = 16'd40;
                4'h4: div_x10 = 16'd50;
                4'h5: div_x10 = 16'd80;
                4'h6: div_x10 = 16'd100;
                4'h7: div_x10 = 16'd200;
                4'h8: div_x10 = 16'd250;
                4'h9: div_x10 = 16'd400;
                4'ha: div_x10 = 16'd500;
                4'hb: div_x10 = 16'd800;
                4'hc: div_x10 = 16'd1000;
                4'hd: div_x10 = 16'd1250;
                4'he: div_x10 = 16'd2000;
                default: div_x10 = 16'd2500;
            endcase
        end
    endfunction

    function sgt;
        input [23:0] a;
        input [23:0] b;
        begin
            sgt = $signed(a) > $signed(b);
        end
    endfunction

    // ****************
    // registers
    // ****************
    reg  [31:0] ctrl_ff;
    reg  [31:0] comm_ff;
    reg  [23:0] pos_lim_ff;
    reg  [23:0] neg_lim_ff;
    reg  [9:0]  rxp_ff;
    reg  [13:0] to_ff;
    reg  [17:0] gear_a_ff;
    reg  [17:0] gear_b_ff;
    reg  [23:0] pos_cmd_ff;
    reg  [23:0] pos_act_ff;
    reg  [4:0]  irq_stat_ff;
    reg  [4:0]  irq_mask_ff;
    reg  [3:0]  err_cnt_ff;
    reg  [1:0]  stop_s_ff;
    reg  [1:0]  start_s_ff;
    reg  [1:0]  fwd_s_ff;
    reg  [1:0]  rev_s_ff;
    reg         start_d_ff;
    reg  [31:0] rdy_cnt_ff;
    reg         fwd_block_ff;
    reg         rev_block_ff;
    reg  [4:0]  ev;

    wire        legacy    = comm_ff[`COMM_PROTO];            // see R10
    wire [1:0]  parity    = comm_ff[`COMM_PAR_LSB+1:`COMM_PAR_LSB]; // see R11
    wire        two_stop  = comm_ff[`COMM_STOP2];            // see R12
    wire [3:0]  err_limit = comm_ff[`COMM_ERRLIM_LSB+3:`COMM_ERRLIM_LSB];
    wire [1:0]  so_action = ctrl_ff[`CTRL_SO_LSB+1:`CTRL_SO_LSB];
    wire [3:0]  angle     = ctrl_ff[`CTRL_ANGLE_LSB+3:`CTRL_ANGLE_LSB];
    // stop level active-high after contact sense
    wire        stop_act  = ctrl_ff[`CTRL_STOP_NC] ? ~stop_s_ff[1]
                                                   : stop_s_ff[1]; // see R19
    wire        wr_hit    = wr && clk_en;

    // ****************
    // link supervision
    // ****************
    wire        to_exp;
    wire        rxp_exp;
    // timeout only watched under Modbus RTU
    pulse_timer #(.TICK_CYC(`CYC_PER_MS), .W(14)) u_to (
        .mclk       (mclk),
        .reset      (reset),
        .clk_en     (clk_en),
        .restart    (link_frame_ok),
        .limit      (legacy ? 14'h0 : to_ff),            // see R13 R14
        .expired_ff (to_exp)
    );
    pulse_timer #(.TICK_CYC(`CYC_PER_10MS), .W(14)) u_rxp (
        .mclk       (mclk),
        .reset      (reset),
        .clk_en     (clk_en),
        .restart    (link_frame_ok),
        .limit      (legacy ? {4'h0, rxp_ff} : 14'h0),    // see R4 R5
        .expired_ff (rxp_exp)
    );

    // ****************************************************************
    // register writes
    // ****************************************************************
    always @(posedge mclk) begin
        if (reset) begin
            ctrl_ff    <= `CTRL_RESET;
            comm_ff    <= `COMM_RESET;
            pos_lim_ff <= `POS_LIMIT_RESET;                  // see R1
            neg_lim_ff <= `NEG_LIMIT_RESET;                  // see R1
            rxp_ff     <= 10'h0;
            to_ff      <= 14'h0;
            gear_a_ff  <= `GEAR_RESET;                       // see R7
            gear_b_ff  <= `GEAR_RESET;
            pos_cmd_ff <= 24'h0;
            pos_act_ff <= 24'h0;
            irq_mask_ff <= 5'h0;
        end else if (wr_hit) begin
            case (addr)
                `REG_CTRL: begin
                    ctrl_ff <= wdata & 32'h0000_3f3f;
                    if (wdata[`CTRL_SO_LSB+1:`CTRL_SO_LSB] == 2'h3)
                        ctrl_ff[`CTRL_SO_LSB+1:`CTRL_SO_LSB] <= 2'h0;
                end
                `REG_COMM: begin
                    comm_ff <= wdata & 32'h0000_00ff;
                    if (wdata[2:1] == 2'h3)
                        comm_ff[2:1] <= 2'h1;
                    if (wdata[7:4] == 4'h0 || wdata[7:4] > 4'ha)
                        comm_ff[7:4] <= 4'h3;
                end
                `REG_POS_LIMIT: pos_lim_ff <= wdata[23:0];
                `REG_NEG_LIMIT: neg_lim_ff <= wdata[23:0];
                `REG_RX_PERIOD: rxp_ff <= (wdata[9:0] > `RXP_MAX)
                                          ? `RXP_MAX : wdata[9:0];
                `REG_TIMEOUT:   to_ff <= (wdata[13:0] > `TO_MAX)
                                         ? `TO_MAX : wdata[13:0];
                `REG_GEAR_A:    gear_a_ff <= wdata[17:0];
                `REG_GEAR_B:    gear_b_ff <= wdata[17:0];
                `REG_POS_CMD:   pos_cmd_ff <= wdata[23:0];
                `REG_POS_ACT:   pos_act_ff <= wdata[23:0];
                `REG_IRQ_MASK:  irq_mask_ff <= wdata[4:0];
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // input sync, ready sequencing, run gating
    // ****************************************************************
    wire over_pos = sgt(pos_cmd_ff, pos_lim_ff) || sgt(pos_act_ff, pos_lim_ff);
    wire over_neg = sgt(neg_lim_ff, pos_cmd_ff) || sgt(neg_lim_ff, pos_act_ff);
    wire ot_chk   = ctrl_ff[`CTRL_SW_OT];

    always @(posedge mclk) begin
        if (reset) begin
            stop_s_ff     <= 2'h0;
            start_s_ff    <= 2'h0;
            fwd_s_ff      <= 2'h0;
            rev_s_ff      <= 2'h0;
            start_d_ff    <= 1'b0;
            rdy_cnt_ff    <= 32'h0;
            ready_ff      <= 1'b0;
            move_start_ff <= 1'b0;
            run_fwd_ff    <= 1'b0;
            run_rev_ff    <= 1'b0;
            fwd_block_ff  <= 1'b0;
            rev_block_ff  <= 1'b0;
            halt_ff       <= 1'b0;
            halt_decel_ff <= 1'b0;
        end else if (clk_en) begin
            stop_s_ff  <= {stop_s_ff[0], stop_pin};
            start_s_ff <= {start_s_ff[0], start_pin};
            fwd_s_ff   <= {fwd_s_ff[0], forward_run_request};
            rev_s_ff   <= {rev_s_ff[0], reverse_run_request};
            start_d_ff <= start_s_ff[1];
            // power-up wait, then ready while stop is inactive
            if (rdy_cnt_ff != READY_CYC - 1)
                rdy_cnt_ff <= rdy_cnt_ff + 32'h1;            // see R18
            ready_ff <= (rdy_cnt_ff == READY_CYC - 1) && !stop_act; // see R16
            fwd_block_ff <= ot_chk && over_pos;              // see R2
            rev_block_ff <= ot_chk && over_neg;              // see R2
            move_start_ff <= ready_ff && start_s_ff[1] && !start_d_ff
                             && !(ot_chk && (over_pos || over_neg)); // see R16
            run_fwd_ff <= ready_ff && fwd_s_ff[1] && !rev_s_ff[1]
                          && !(ot_chk && over_pos);          // see R17 R2
            run_rev_ff <= ready_ff && rev_s_ff[1] && !fwd_s_ff[1]
                          && !(ot_chk && over_neg);          // see R17 R2
            if (to_exp || (ot_chk && (over_pos || over_neg)) || stop_act) begin
                halt_ff       <= 1'b1;                       // see R3
                halt_decel_ff <= to_exp && ctrl_ff[`CTRL_TO_DECEL]; // see R3
            end else if (move_start_ff || run_fwd_ff || run_rev_ff) begin
                halt_ff       <= 1'b0;
                halt_decel_ff <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // error counting, stepout reaction, interrupts
    // ****************************************************************
    always @* begin
        ev = 5'h0;
        ev[`IRQ_SW_OT]    = ot_chk && (over_pos || over_neg);
        ev[`IRQ_TIMEOUT]  = to_exp;
        ev[`IRQ_STEPOUT]  = stepout_det && ctrl_ff[`CTRL_STEPOUT_EN];
        ev[`IRQ_COMM_ERR] = link_frame_err && (err_cnt_ff + 4'h1 >= err_limit);
        ev[`IRQ_RXP]      = rxp_exp;
    end

    always @(posedge mclk) begin
        if (reset) begin
            err_cnt_ff  <= 4'h0;
            warning_ff  <= 1'b0;
            alarm_ff    <= 1'b0;
            irq_stat_ff <= 5'h0;
            irq_ff      <= 1'b0;
        end else if (clk_en) begin
            // status clear first so a same-cycle event still sets
            if (wr_hit && addr == `REG_STATUS && wdata[0]) begin
                alarm_ff   <= 1'b0;
                warning_ff <= 1'b0;
                err_cnt_ff <= 4'h0;
            end
            if (link_frame_ok)
                err_cnt_ff <= 4'h0;
            else if (link_frame_err && err_cnt_ff != 4'hf)
                err_cnt_ff <= err_cnt_ff + 4'h1;             // see R15
            if (ev[`IRQ_COMM_ERR])
                alarm_ff <= 1'b1;                            // see R15
            if (ev[`IRQ_STEPOUT] && so_action == 2'h2)
                alarm_ff <= 1'b1;                            // see R6
            if (ev[`IRQ_STEPOUT] && so_action == 2'h1)
                warning_ff <= 1'b1;                          // see R6
            // set wins over write-one-to-clear
            if (wr_hit && addr == `REG_IRQ_STAT)
                irq_stat_ff <= (irq_stat_ff & ~wdata[4:0]) | ev;
            else
                irq_stat_ff <= irq_stat_ff | ev;
            irq_ff <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    // ****************
    // read port
    // ****************
    always @(posedge mclk) begin
        if (reset) begin
            rdata_ff <= 32'h0;
        end else if (clk_en) begin
            rdata_ff <= 32'h0;
            if (rd) begin
                case (addr)
                    `REG_CTRL:      rdata_ff <= ctrl_ff;
                    `REG_POS_LIMIT: rdata_ff <= {{8{pos_lim_ff[23]}}, pos_lim_ff};
                    `REG_NEG_LIMIT: rdata_ff <= {{8{neg_lim_ff[23]}}, neg_lim_ff};
                    `REG_COMM:      rdata_ff <= comm_ff;
                    `REG_RX_PERIOD: rdata_ff <= {22'h0, rxp_ff};
                    `REG_TIMEOUT:   rdata_ff <= {18'h0, to_ff};
                    `REG_GEAR_A:    rdata_ff <= {14'h0, gear_a_ff};
                    `REG_GEAR_B:    rdata_ff <= {14'h0, gear_b_ff};
                    `REG_POS_CMD:   rdata_ff <= {{8{pos_cmd_ff[23]}}, pos_cmd_ff};
                    `REG_POS_ACT:   rdata_ff <= {{8{pos_act_ff[23]}}, pos_act_ff};
                    `REG_STATUS:    rdata_ff <= {16'h0, err_cnt_ff, 1'b0,
                                        parity, two_stop, halt_decel_ff,
                                        halt_ff, fwd_block_ff, rev_block_ff,
                                        alarm_ff, warning_ff, stop_act,
                                        ready_ff};
                    `REG_IRQ_STAT:  rdata_ff <= {27'h0, irq_stat_ff};
                    `REG_IRQ_MASK:  rdata_ff <= {27'h0, irq_mask_ff};
                    `REG_MOTION:    rdata_ff <= {7'h0, ctrl_ff[`CTRL_HIRES],
                                        div_x10(angle), 8'h0}; // see R8 R9
                    default:        rdata_ff <= 32'h0;
                endcase
            end
        end
    end
endmodule

// [stepper_drive_sva.sv]
// assertions on the ports of the stepper drive configuration block
`timescale 1ns/10ps
`include "stepper_cfg_defines.vh"
module stepper_drive_sva #(
    parameter READY_CYC = 20
) (
    input wire        mclk,
    input wire        reset,
    input wire        clk_en,
    input wire [3:0]  addr,
    input wire [31:0] wdata,
    input wire        wr,
    input wire        rd,
    input wire [31:0] rdata_ff,
    input wire        stop_pin,
    input wire        link_frame_err,
    input wire        stepout_det,
    input wire        ready_ff,
    input wire        move_start_ff,
    input wire        run_fwd_ff,
    input wire        run_rev_ff,
    input wire        halt_ff,
    input wire        warning_ff,
    input wire        alarm_ff,
    input wire        irq_ff
);
    // ****************
    // cycles since reset, and stop seen low since reset
    // ****************
    reg [31:0] cnt_ff;
    reg        stop_lo_ff;
    always @(posedge mclk) begin
        if (reset) begin
            cnt_ff     <= 32'h0;
            stop_lo_ff <= 1'b0;
        end else begin
            if (clk_en && cnt_ff < READY_CYC + 8)
                cnt_ff <= cnt_ff + 32'h1;
            if (!stop_pin)
                stop_lo_ff <= 1'b1;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    a_reset_quiet: assert property ($fell(reset) |-> !ready_ff && !irq_ff
        && !alarm_ff && !warning_ff && !halt_ff && rdata_ff == 32'h0)
        else $error("outputs not cleared by reset");
    a_rdata_idle: assert property (clk_en && !rd |=> rdata_ff == 32'h0)
        else $error("read data outside its cycle");
    a_start_ready: assert property (move_start_ff |-> $past(ready_ff))
        else $error("start accepted without ready");
    a_start_pulse: assert property (move_start_ff |=> !move_start_ff)
        else $error("start pulse too long");
    a_run_ready: assert property ((run_fwd_ff || run_rev_ff) |-> $past(ready_ff))
        else $error("run accepted without ready");
    a_run_excl: assert property (!(run_fwd_ff && run_rev_ff))
        else $error("both run directions active");
    a_ready_early: assert property (ready_ff |-> cnt_ff >= READY_CYC)
        else $error("ready too early");
    a_ready_late: assert property (cnt_ff == READY_CYC + 6 && !stop_lo_ff
        |-> ready_ff)
        else $error("ready too late");
    a_warn_sticky: assert property ($fell(warning_ff) |-> $past(wr)
        && $past(addr) == `REG_STATUS && $past(wdata[0]))
        else $error("warning cleared without status write");
    a_alarm_cause: assert property ($rose(alarm_ff)
        |-> $past(stepout_det) || $past(link_frame_err))
        else $error("alarm without cause");
endmodule
bind stepper_drive_config_control stepper_drive_sva #(
    .READY_CYC(READY_CYC)
) u_sva (.mclk(mclk), .reset(reset), .clk_en(clk_en), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata_ff(rdata_ff),
    .stop_pin(stop_pin), .link_frame_err(link_frame_err),
    .stepout_det(stepout_det), .ready_ff(ready_ff),
    .move_start_ff(move_start_ff), .run_fwd_ff(run_fwd_ff),
    .run_rev_ff(run_rev_ff), .halt_ff(halt_ff), .warning_ff(warning_ff),
    .alarm_ff(alarm_ff), .irq_ff(irq_ff));

// [tb_stepper_drive_config_control.sv]
// self-checking bench for the stepper drive configuration block
`timescale 1ns/10ps
`include "stepper_cfg_defines.vh"
module tb_stepper_drive_config_control;
    reg mclk = 1'b0, reset = 1'b1, clk_en = 1'b1, wr = 1'b0, rd = 1'b0;
    reg [3:0]  addr = 4'h0;
    reg [31:0] wdata = 32'h0;
    reg stop_pin = 1'b1, start_pin = 1'b0, stepout_det = 1'b0, send = 1'b0;
    reg forward_run_request = 1'b0, reverse_run_request = 1'b0;
    reg [1:0] dev_parity = 2'h1, mst_parity = 2'h1;
    wire [31:0] rdata_ff;
    wire ready_ff, move_start_ff, run_fwd_ff, run_rev_ff, halt_ff;
    wire halt_decel_ff, warning_ff, alarm_ff, irq_ff, f_ok, f_err;
    integer n_errors = 0, n_checks = 0, cyc = 0;
    localparam [255:0] DIVS = {16'h09c4, 16'h07d0, 16'h04e2, 16'h03e8,
        16'h0320, 16'h01f4, 16'h0190, 16'h00fa, 16'h00c8, 16'h0064,
        16'h0050, 16'h0032, 16'h0028, 16'h0019, 16'h0014, 16'h000a};
    stepper_drive_config_control #(.READY_CYC(20)) dut (.mclk(mclk),
        .reset(reset), .clk_en(clk_en), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata_ff(rdata_ff), .stop_pin(stop_pin),
        .start_pin(start_pin), .forward_run_request(forward_run_request),
        .reverse_run_request(reverse_run_request), .link_frame_ok(f_ok),
        .link_frame_err(f_err), .stepout_det(stepout_det),
        .ready_ff(ready_ff), .move_start_ff(move_start_ff),
        .run_fwd_ff(run_fwd_ff), .run_rev_ff(run_rev_ff), .halt_ff(halt_ff),
        .halt_decel_ff(halt_decel_ff), .warning_ff(warning_ff),
        .alarm_ff(alarm_ff), .irq_ff(irq_ff));
    link_master_model master (.mclk(mclk), .send(send),
        .dev_parity(dev_parity), .dev_two_stop(1'b0),
        .mst_parity(mst_parity), .mst_two_stop(1'b0),
        .link_frame_ok(f_ok), .link_frame_err(f_err));
    always #25 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc == 70000) begin
            n_errors = n_errors + 1;
            print_verdict;
        end
    end
    // ****************
    // tasks and expectations
    // ****************
    function [15:0] div10(input [3:0] c);
        div10 = DIVS[{c, 4'h0} +: 16];
    endfunction
    task print_verdict;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task wr_reg(input [3:0] a, input [31:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task rd_reg(input [3:0] a, output [31:0] d);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata_ff;
    endtask
    task rchk(input [3:0] a, input [31:0] exp);
        reg [31:0] d;
        rd_reg(a, d);
        chk(d, exp);
    endtask
    task cycles(input integer n);
        repeat (n) @(posedge mclk);
    endtask
    task frame;
        @(posedge mclk);
        send <= 1'b1;
        @(posedge mclk);
        send <= 1'b0;
        cycles(3);
    endtask
    task wait_ready;
        integer k;
        for (k = 0; k < 40 && ready_ff !== 1'b1; k = k + 1)
            @(posedge mclk);
        chk(ready_ff, 1'b1);
    endtask
    // ****************
    // main sequence
    // ****************
    initial begin : main
        reg [31:0] v;
        integer    i;
        void'($urandom(37316));
        cycles(8);
        reset               <= 1'b0;
        forward_run_request <= 1'b1;
        start_pin           <= 1'b1;
        cycles(5);
        chk({ready_ff, run_fwd_ff, move_start_ff}, 3'h0);
        rchk(`REG_CTRL, 32'h0000_0033);
        rchk(`REG_POS_LIMIT, 32'h007f_ffff);
        rchk(`REG_NEG_LIMIT, 32'hff80_0000);
        rchk(`REG_COMM, 32'h0000_0032);
        rchk(`REG_RX_PERIOD, 32'h0);
        rchk(`REG_TIMEOUT, 32'h0);
        rchk(`REG_GEAR_A, 32'h0000_01f4);
        rchk(`REG_GEAR_B, 32'h0000_01f4);
        rchk(4'he, 32'h0);
        wait_ready;
        cycles(5);
        chk(run_fwd_ff, 1'b1);
        reverse_run_request <= 1'b1;
        cycles(5);
        chk({run_fwd_ff, run_rev_ff}, 2'h0);
        forward_run_request <= 1'b0;
        reverse_run_request <= 1'b0;
        start_pin           <= 1'b0;
        cycles(4);
        start_pin <= 1'b1;
        i = 0;
        repeat (8) begin
            @(posedge mclk);
            #1 i = i + move_start_ff;
        end
        chk(i, 1);
        wr_reg(`REG_CTRL, 32'h23);
        cycles(5);
        chk(ready_ff, 1'b0);
        stop_pin <= 1'b0;
        wait_ready;
        for (i = 0; i < 4; i = i + 1) begin
            v = $urandom;
            wr_reg(`REG_POS_LIMIT, v);
            rchk(`REG_POS_LIMIT, {{8{v[23]}}, v[23:0]});
            wr_reg({3'h3, i[0]}, v);
            rchk({3'h3, i[0]}, {14'h0, v[17:0]});
        end
        wr_reg(`REG_POS_LIMIT, 32'h007f_ffff);
        for (i = 0; i < 16; i = i + 1) begin
            v = $urandom;
            wr_reg(`REG_CTRL, {20'h0, i[3:0], 4'h2, v[0], 3'h3});
            rchk(`REG_MOTION, {7'h0, v[0], div10(i[3:0]), 8'h0});
        end
        wr_reg(`REG_IRQ_STAT, 32'h1f);
        for (i = 0; i < 3; i = i + 1) begin
            wr_reg(`REG_CTRL, {18'h0, i[1:0], 12'h027});
            wr_reg(`REG_IRQ_MASK, (i == 0) ? 32'h0 : 32'h4);
            @(posedge mclk);
            stepout_det <= 1'b1;
            @(posedge mclk);
            stepout_det <= 1'b0;
            cycles(3);
            chk({warning_ff, alarm_ff, irq_ff}, {i == 1, i == 2, i != 0});
            rchk(`REG_IRQ_STAT, 32'h4);
            wr_reg(`REG_IRQ_STAT, 32'h4);
            wr_reg(`REG_STATUS, 32'h1);
            cycles(2);
            chk({warning_ff, alarm_ff, irq_ff}, 3'h0);
        end
        for (i = 0; i < 8; i = i + 1) begin
            wr_reg(`REG_COMM, {24'h0, 4'h2, i[0], i[2:1], 1'b0});
            rd_reg(`REG_STATUS, v);
            chk(v[10:8], {(i[2:1] == 2'h3) ? 2'h1 : i[2:1], i[0]});
        end
        wr_reg(`REG_COMM, 32'h24);
        dev_parity <= 2'h2;
        frame;
        chk(alarm_ff, 1'b0);
        frame;
        chk(alarm_ff, 1'b1);
        rchk(`REG_IRQ_STAT, 32'h8);
        mst_parity <= 2'h2;
        wr_reg(`REG_IRQ_STAT, 32'h1f);
        wr_reg(`REG_STATUS, 32'h1);
        frame;
        chk(alarm_ff, 1'b0);
        wr_reg(`REG_POS_LIMIT, 32'h64);
        wr_reg(`REG_POS_CMD, 32'h64);
        rd_reg(`REG_STATUS, v);
        chk(v[5], 1'b0);
        wr_reg(`REG_POS_CMD, 32'h65);
        forward_run_request <= 1'b1;
        cycles(6);
        chk(run_fwd_ff, 1'b0);
        rd_reg(`REG_STATUS, v);
        chk(v[5], 1'b1);
        rchk(`REG_IRQ_STAT, 32'h1);
        forward_run_request <= 1'b0;
        wr_reg(`REG_POS_CMD, 32'h0);
        wr_reg(`REG_POS_LIMIT, 32'h007f_ffff);
        wr_reg(`REG_IRQ_STAT, 32'h1f);
        for (i = 2; i >= 0; i = i - 1) begin
            wr_reg(`REG_CTRL, {26'h0, i[0], 5'h03});
            wr_reg(`REG_COMM, {31'h12, i[1]});
            wr_reg(`REG_TIMEOUT, 32'h1);
            frame;
            cycles(20050);
            chk({halt_ff, halt_decel_ff}, {1'b1, i[0]});
            rchk(`REG_IRQ_STAT, (i == 2) ? 32'h0 : 32'h2);
            wr_reg(`REG_IRQ_STAT, 32'h1f);
        end
        wr_reg(`REG_TIMEOUT, 32'h0);
        clk_en <= 1'b0;
        wr_reg(`REG_IRQ_MASK, 32'h1f);
        clk_en <= 1'b1;
        rchk(`REG_IRQ_MASK, 32'h4);
        print_verdict;
    end
endmodule
